/* File: bit_set_file_exec.sv */
// bit-set-in-file instruction decoder and executor with an axi4-lite slave
//
// Function
// - set chosen bit, keep other seven
// - access flag zero uses fixed access bank
// - access flag one uses bank select register
// - extended set: low addresses index literal offset
//
// Register access over AXI4-Lite and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "bit_set_map.svh"

module bit_set_file_exec
    import bit_set_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);
    // --------------------------------------------------------------
    // parameter check
    // --------------------------------------------------------------
    // the address forms below are 12 bits wide
    if (ADDR_W != 12) begin : g_bad_width
        $error("ADDR_W must be 12");
    end

    // --------------------------------------------------------------
    // functions
    // --------------------------------------------------------------
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0]  strb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[8*i +: 8] = nw[8*i +: 8];
            end
        end
        return res;
    endfunction

    function automatic logic mapped(input logic [7:0] a);
        return a == `OFS_CTRL || a == `OFS_BANK || a == `OFS_INDEX_BASE
            || a == `OFS_INSTR || a == `OFS_STATUS || a == `OFS_MEM_ADDR
            || a == `OFS_MEM_DATA;
    endfunction

    // --------------------------------------------------------------
    // state
    // --------------------------------------------------------------
    exec_state_t  state;
    logic         ext_set_en;
    logic [3:0]   bank_select_reg;
    logic [11:0]  index_base;
    instr_word_t  instr;
    logic         bad_opcode;
    logic [11:0]  target;
    logic [7:0]   operand;
    logic [11:0]  mem_addr;
    logic         aw_got;
    logic         w_got;
    logic [7:0]   aw_addr;
    logic [31:0]  w_data;
    logic [3:0]   w_strb;
    mem_write_t   exec_wr;
    mem_write_t   sw_wr;
    mem_write_t   ram_wr;
    logic [7:0]   exec_rdata;
    logic [7:0]   sw_rdata;
    logic         do_write;
    logic         issue;
    logic [31:0]  wmerged;
    logic [31:0]  read_word;
    logic [31:0]  current;
    logic [11:0]  next_target;

    assign do_write = aw_got && w_got && !s_axi_bvalid;
    assign wmerged  = merge(current, w_data, w_strb);
    // a new instruction is refused while one is still in flight
    // the write-back cycle still counts as busy, so it refuses too
    assign issue    = do_write && aw_addr == `OFS_INSTR && state == st_idle
                      && !exec_wr.en;

    // --------------------------------------------------------------
    // register read view
    // --------------------------------------------------------------
    always_comb begin
        read_word = 32'h0000_0000;
        case (aw_addr)
            `OFS_CTRL:       read_word[`CTRL_EXT_EN_BIT] = ext_set_en;
            `OFS_BANK:       read_word[3:0] = bank_select_reg;
            `OFS_INDEX_BASE: read_word[11:0] = index_base;
            `OFS_INSTR:      read_word[15:0] = instr;
            `OFS_MEM_ADDR:   read_word[11:0] = mem_addr;
            `OFS_MEM_DATA:   read_word[7:0] = sw_rdata;
            default:         read_word = 32'h0000_0000;
        endcase
        current = read_word;
    end

    // --------------------------------------------------------------
    // axi write channel
    // --------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            aw_got        <= 1'b0;
            w_got         <= 1'b0;
            aw_addr       <= 8'h00;
            w_data        <= 32'h0000_0000;
            w_strb        <= 4'h0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got        <= 1'b1;
                aw_addr       <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got        <= 1'b1;
                w_data       <= s_axi_wdata;
                w_strb       <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (do_write) begin
                aw_got       <= 1'b0;
                w_got        <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= mapped(aw_addr) ? `RESP_OKAY : `RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // --------------------------------------------------------------
    // software-written registers
    // --------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ext_set_en      <= `RESET_CTRL;
            bank_select_reg <= `RESET_BANK;
            index_base      <= `RESET_INDEX_BASE;
            mem_addr        <= 12'h000;
        end else if (do_write) begin
            case (aw_addr)
                `OFS_CTRL:       ext_set_en <= wmerged[`CTRL_EXT_EN_BIT];
                `OFS_BANK:       bank_select_reg <= wmerged[3:0];
                `OFS_INDEX_BASE: index_base <= wmerged[11:0];
                `OFS_MEM_ADDR:   mem_addr <= wmerged[11:0];
                default:         ;
            endcase
        end
    end

    // byte writes by software are dropped while the core is executing
    assign sw_wr.en   = do_write && aw_addr == `OFS_MEM_DATA && state == st_idle
                        && w_strb[0];
    assign sw_wr.addr = mem_addr;
    assign sw_wr.data = w_data[7:0];
    assign ram_wr     = exec_wr.en ? exec_wr : sw_wr;

    // --------------------------------------------------------------
    // address formation
    // --------------------------------------------------------------
    always_comb begin
        next_target = {`ACCESS_LOW_BANK, instr.file};
        if (instr.access) begin
            next_target = {bank_select_reg, instr.file};
        end else if (ext_set_en && instr.file <= `INDEXED_LIMIT) begin
            next_target = index_base + {4'h0, instr.file};
        end else if (instr.file >= `ACCESS_SPLIT) begin
            next_target = {`ACCESS_HIGH_BANK, instr.file};
        end
    end

    // --------------------------------------------------------------
    // execution sequence
    // --------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state      <= st_idle;
            instr      <= `RESET_INSTR;
            target     <= 12'h000;
            operand    <= 8'h00;
            bad_opcode <= 1'b0;
            exec_wr    <= '0;
        end else begin
            exec_wr.en <= 1'b0;
            // sticky flag: a fresh bad opcode wins over the clear
            if (do_write && aw_addr == `OFS_STATUS && w_strb[0]
                && w_data[`STATUS_BAD_OP_BIT]) begin
                bad_opcode <= 1'b0;
            end
            case (state)
                st_idle: begin
                    if (issue) begin
                        instr <= wmerged[15:0];
                        state <= st_decode;
                    end
                end
                st_decode: begin
                    if (instr.opcode == `OPCODE_BIT_SET) begin
                        target <= next_target;
                        state  <= st_read;
                    end else begin
                        bad_opcode <= 1'b1;
                        state      <= st_idle;
                    end
                end
                st_read: begin
                    operand <= exec_rdata;
                    state   <= st_process;
                end
                st_process: begin
                    operand <= operand | (8'h01 << instr.bit_num);
                    state   <= st_write;
                end
                st_write: begin
                    exec_wr <= '{en: 1'b1, addr: target, data: operand};
                    state   <= st_idle;
                end
                default: state <= st_idle;
            endcase
        end
    end

    // --------------------------------------------------------------
    // axi read channel
    // --------------------------------------------------------------
    logic [31:0] rword;
    always_comb begin
        rword = 32'h0000_0000;
        case (s_axi_araddr)
            `OFS_CTRL:       rword[`CTRL_EXT_EN_BIT] = ext_set_en;
            `OFS_BANK:       rword[3:0] = bank_select_reg;
            `OFS_INDEX_BASE: rword[11:0] = index_base;
            `OFS_INSTR:      rword[15:0] = instr;
            `OFS_STATUS: begin
                rword[`STATUS_BUSY_BIT]   = state != st_idle || exec_wr.en;
                rword[`STATUS_BAD_OP_BIT] = bad_opcode;
                rword[`STATUS_ADDR_LSB +: 12] = target;
            end
            `OFS_MEM_ADDR:   rword[11:0] = mem_addr;
            `OFS_MEM_DATA:   rword[7:0] = sw_rdata;
            default:         rword = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rword;
            s_axi_rresp   <= mapped(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // --------------------------------------------------------------
    // data memory
    // --------------------------------------------------------------
    data_ram #(
        .ADDR_W (ADDR_W)
    ) u_ram (
        .aclk    (aclk),
        .aresetn (aresetn),
        .wr      (ram_wr),
        .raddr_a (target),
        .raddr_b (mem_addr),
        .rdata_a (exec_rdata),
        .rdata_b (sw_rdata)
    );
endmodule // bit_set_file_exec

`default_nettype wire

/* File: bit_set_file_exec_checker.sv */
// assertions on the axi4-lite slave ports of the bit-set executor
`timescale 1ns/1ps
`default_nettype none
`include "bit_set_map.svh"

module bit_set_file_exec_checker
    import bit_set_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic [7:0]  s_axi_awaddr,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0]  s_axi_wstrb,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [7:0]  s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready
);
    wire aw_go  = s_axi_awvalid && s_axi_awready;
    wire w_go   = s_axi_wvalid && s_axi_wready;
    wire ar_go  = s_axi_arvalid && s_axi_arready;
    // offsets past the last register are refused
    wire ar_bad = s_axi_araddr > `OFS_MEM_DATA;

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // ----------------------------------------------------------------------
    // bus answers
    // ----------------------------------------------------------------------
    w_lat_a: assert property (aw_go && w_go |-> ##1 !s_axi_bvalid ##1 s_axi_bvalid)
        else $error("write response not two edges after handshake");
    w_bad_a: assert property (aw_go && w_go && s_axi_awaddr > `OFS_MEM_DATA
        |-> ##2 s_axi_bresp == `RESP_SLVERR)
        else $error("unmapped write not refused");
    b_hold_a: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped before bready");
    b_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("new write accepted before response taken");
    b_back_a: assert property (s_axi_bvalid && s_axi_bready
        |=> s_axi_awready && s_axi_wready)
        else $error("write channels not reopened");
    r_lat_a: assert property (ar_go |=> s_axi_rvalid && !s_axi_arready)
        else $error("read answer not one edge after handshake");
    r_bad_a: assert property (ar_go && ar_bad
        |=> s_axi_rresp == `RESP_SLVERR && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
    r_ok_a: assert property (ar_go && !ar_bad && s_axi_araddr[1:0] == 2'h0
        |=> s_axi_rresp == `RESP_OKAY)
        else $error("mapped read not okay");
    r_hold_a: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data changed before rready");
    r_back_a: assert property (s_axi_rvalid && s_axi_rready
        |=> s_axi_arready && !s_axi_rvalid)
        else $error("read channel not reopened");

    cover property (aw_go && w_go);
    cover property (ar_go && ar_bad);
    cover property (s_axi_rvalid && !s_axi_rready);
endmodule // bit_set_file_exec_checker

bind bit_set_file_exec bit_set_file_exec_checker #(.ADDR_W(ADDR_W)) u_chk (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready)
);
`default_nettype wire

/* File: bit_set_file_exec_test.sv */
// self-checking bench for the bit-set executor
`timescale 1ns/1ps
`default_nettype none
`include "bit_set_map.svh"

module bit_set_file_exec_test
    import bit_set_pkg::*;
;
    logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
    int          miscompares, total_checks;

    bit_set_file_exec #(.ADDR_W(12)) u_dut (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
    );

    always #5 aclk = ~aclk;

    // ----------------------------------------------------------------------
    // bus and compare tasks
    // ----------------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] t=%0t resp got=%h exp=%h", $time, got, exp);
        end
    endtask

    // st holds bready low for that many cycles to stall the slave
    // no cycle limit here: only the watchdog ends a wait
    task automatic axw(input logic [7:0] a, input logic [31:0] d, input int st);
        int i = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        forever begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid && s_axi_bready) break;
            if (i >= st) s_axi_bready <= 1'b1;
            i++;
        end
        rs = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    task automatic axr(input logic [7:0] a, input int st);
        int i = 0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        forever begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid && s_axi_rready) break;
            if (i >= st) s_axi_rready <= 1'b1;
            i++;
        end
        rd = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        axw(a, d, 0);
        chk_resp(rs, er);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        axr(a, 0);
        chk(rd, ed);
        chk_resp(rs, er);
    endtask

    task automatic mem_put(input logic [11:0] a, input logic [7:0] d);
        wr(`OFS_MEM_ADDR, {20'h0, a}, `RESP_OKAY);
        wr(`OFS_MEM_DATA, {24'h0, d}, `RESP_OKAY);
    endtask

    // issue, wait for busy to clear, then check target and byte
    task automatic exec(input logic [15:0] ins, input logic [11:0] ea, input logic [7:0] eb);
        wr(`OFS_INSTR, {16'h0, ins}, `RESP_OKAY);
        for (int i = 0; i < 20; i++) begin
            axr(`OFS_STATUS, 0);
            if (rd[0] === 1'b0) break;
        end
        chk(rd, {4'h0, ea, 16'h0});
        wr(`OFS_MEM_ADDR, {20'h0, ea}, `RESP_OKAY);
        rdc(`OFS_MEM_DATA, {24'h0, eb}, `RESP_OKAY);
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // ----------------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------------
    task automatic t_reset();
        for (int k = 0; k < 7; k++) rdc(8'(k * 4), 32'h0, `RESP_OKAY);
        rdc(8'h1c, 32'h0, `RESP_SLVERR);
        wr(8'h20, 32'h1, `RESP_SLVERR);
        axw(`OFS_BANK, 32'h5, 3);
        axr(`OFS_BANK, 2);
        chk(rd, 32'h5);
        // lane 0 masked off: the bank field must not move
        s_axi_wstrb <= 4'he;
        wr(`OFS_BANK, 32'ha, `RESP_OKAY);
        s_axi_wstrb <= 4'hf;
        rdc(`OFS_BANK, 32'h5, `RESP_OKAY);
    endtask

    task automatic t_bank();
        mem_put(12'h523, 8'h0a);
        exec({`OPCODE_BIT_SET, 3'd7, 1'b1, 8'h23}, 12'h523, 8'h8a);
        for (int b = 0; b < 8; b++)
            exec({`OPCODE_BIT_SET, 3'(b), 1'b1, 8'ha0}, 12'h5a0, 8'((2 << b) - 1));
    endtask

    task automatic t_access();
        mem_put(12'h040, 8'h10);
        exec({`OPCODE_BIT_SET, 3'd0, 1'b0, 8'h40}, 12'h040, 8'h11);
        exec({`OPCODE_BIT_SET, 3'd3, 1'b0, 8'h80}, 12'hf80, 8'h08);
        // this issue runs; the one from exec below lands while it is in flight and is ignored
        wr(`OFS_INSTR, {16'h0, `OPCODE_BIT_SET, 3'd6, 1'b0, 8'h41}, `RESP_OKAY);
        exec({`OPCODE_BIT_SET, 3'd5, 1'b1, 8'h77}, 12'h041, 8'h40);
        wr(`OFS_MEM_ADDR, 32'h577, `RESP_OKAY);
        rdc(`OFS_MEM_DATA, 32'h0, `RESP_OKAY);
    endtask

    task automatic t_indexed();
        wr(`OFS_CTRL, 32'h1, `RESP_OKAY);
        wr(`OFS_INDEX_BASE, 32'h300, `RESP_OKAY);
        exec({`OPCODE_BIT_SET, 3'd1, 1'b0, 8'h5f}, 12'h35f, 8'h02);
        exec({`OPCODE_BIT_SET, 3'd2, 1'b0, 8'h60}, 12'hf60, 8'h04);
        exec({`OPCODE_BIT_SET, 3'd4, 1'b1, 8'h10}, 12'h510, 8'h10);
        wr(`OFS_CTRL, 32'h0, `RESP_OKAY);
    endtask

    // other opcodes leave memory alone
    task automatic t_badop();
        wr(`OFS_INSTR, 32'h9f11, `RESP_OKAY);
        repeat (8) @(posedge aclk);
        axr(`OFS_STATUS, 0);
        chk({30'h0, rd[1:0]}, 32'h2);
        wr(`OFS_MEM_ADDR, 32'h511, `RESP_OKAY);
        rdc(`OFS_MEM_DATA, 32'h0, `RESP_OKAY);
        wr(`OFS_STATUS, 32'h2, `RESP_OKAY);
        axr(`OFS_STATUS, 0);
        chk({30'h0, rd[1:0]}, 32'h0);
    endtask

    initial begin
        aclk = 1'b0;
        aresetn = 1'b0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
        s_axi_awaddr = 8'h0;
        s_axi_araddr = 8'h0;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hf;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_bank();
        t_access();
        t_indexed();
        t_badop();
        close_out();
    end

    initial begin
        #200000;
        miscompares++;
        close_out();
    end
endmodule // bit_set_file_exec_test
`default_nettype wire

/* File: bit_set_map.svh */
// register offsets, field positions and reset values of the bit-set executor
`ifndef BIT_SET_MAP_SVH
`define BIT_SET_MAP_SVH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define OFS_CTRL        8'h00
`define OFS_BANK        8'h04
`define OFS_INDEX_BASE  8'h08
`define OFS_INSTR       8'h0c
`define OFS_STATUS      8'h10
`define OFS_MEM_ADDR    8'h14
`define OFS_MEM_DATA    8'h18

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define CTRL_EXT_EN_BIT     0
`define STATUS_BUSY_BIT     0
`define STATUS_BAD_OP_BIT   1
`define STATUS_ADDR_LSB     16

// ----------------------------------------------------------------------
// decode constants and reset values
// ----------------------------------------------------------------------
`define OPCODE_BIT_SET      4'h8
`define INDEXED_LIMIT       8'h5f
`define ACCESS_SPLIT        8'h60
`define ACCESS_HIGH_BANK    4'hf
`define ACCESS_LOW_BANK     4'h0
`define RESET_CTRL          1'h0
`define RESET_BANK          4'h0
`define RESET_INDEX_BASE    12'h000
`define RESET_INSTR         16'h0000
`define RESP_OKAY           2'h0
`define RESP_SLVERR         2'h2

`endif

/* File: bit_set_pkg.sv */
// types shared by the bit-set executor
package bit_set_pkg;

    typedef enum logic [2:0] {
        st_idle,
        st_decode,
        st_read,
        st_process,
        st_write
    } exec_state_t;

    // one instruction word, split into its fields
    typedef struct packed {
        logic [3:0] opcode;
        logic [2:0] bit_num;
        logic       access;
        logic [7:0] file;
    } instr_word_t;

    typedef struct packed {
        logic        en;
        logic [11:0] addr;
        logic [7:0]  data;
    } mem_write_t;

endpackage

/* File: data_ram.sv */
// byte-wide data memory built from flip-flops, one write and two read ports
`timescale 1ns/1ps
`default_nettype none

module data_ram
    import bit_set_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire mem_write_t        wr,
    input  wire logic [ADDR_W-1:0] raddr_a,
    input  wire logic [ADDR_W-1:0] raddr_b,
    output logic      [7:0]        rdata_a,
    output logic      [7:0]        rdata_b
);
    logic [7:0] cells [0:(1<<ADDR_W)-1];

    // cleared at reset so reads never see an unknown byte
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < (1<<ADDR_W); i++) begin
                cells[i] <= 8'h00;
            end
        end else if (wr.en) begin
            cells[wr.addr[ADDR_W-1:0]] <= wr.data;
        end
    end

    assign rdata_a = cells[raddr_a];
    assign rdata_b = cells[raddr_b];
endmodule // data_ram

`default_nettype wire
